// File: design/cod_alu.sv
`timescale 1ns/10ps
// Byte arithmetic for the decoded operations; result and flags registered.
module cod_alu (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // Operation
   input  wire logic             go,
   input  wire cod_pkg::cod_op_t op,
   input  wire logic [7:0]       acc,
   input  wire logic [7:0]       idx,
   input  wire logic [7:0]       mem,
   input  wire logic [1:0]       src,
   input  wire logic             carry_in,
   // Result
   output logic      [7:0]       result,
   output logic                  flag_n,
   output logic                  flag_z,
   output logic                  flag_c
);
   logic [7:0] next_result;
   logic       next_n;
   logic       next_z;
   logic       next_c;
   logic [8:0] diff;
   logic [7:0] opnd;

   always_comb begin
      next_result = result;
      next_n      = flag_n;
      next_z      = flag_z;
      next_c      = flag_c;
      diff        = 9'h0_00;
      unique case (src)
         cod_pkg::COD_SRC_ACC: opnd = acc;
         cod_pkg::COD_SRC_IDX: opnd = idx;
         default:              opnd = mem;
      endcase
      if (go) begin
         unique case (op)
            cod_pkg::COD_OP_SUB,
            cod_pkg::COD_OP_SUB_BRW: begin
               diff = {1'b0, acc} - {1'b0, mem} -
                      {8'h00, carry_in & (op == cod_pkg::COD_OP_SUB_BRW)};
               next_result = diff[7:0];
               next_c      = diff[8];
            end
            cod_pkg::COD_OP_NEGATE: begin
               diff        = {1'b0, cod_pkg::COD_ZERO_BYTE} - {1'b0, opnd};
               next_result = diff[7:0];
               next_c      = (opnd != cod_pkg::COD_ZERO_BYTE);
            end
            cod_pkg::COD_OP_SHL: begin
               next_result = {opnd[6:0], 1'b0};
               next_c      = opnd[7];
            end
            cod_pkg::COD_OP_TEST:      next_result = opnd;
            cod_pkg::COD_OP_LOAD_ACC,
            cod_pkg::COD_OP_LOAD_IDX:  next_result = mem;
            cod_pkg::COD_OP_STORE_ACC: next_result = acc;
            cod_pkg::COD_OP_STORE_IDX: next_result = idx;
            default:                   next_result = result;
         endcase
         next_n = next_result[7];
         next_z = (next_result == cod_pkg::COD_ZERO_BYTE);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result <= 8'h00;
         flag_n <= 1'b0;
         flag_z <= 1'b0;
         flag_c <= 1'b0;
      end else if (ce) begin
         result <= next_result;
         flag_n <= next_n;
         flag_z <= next_z;
         flag_c <= next_c;
      end
   end
endmodule : cod_alu

// File: design/cod_decoder.sv
`timescale 1ns/10ps
// Operation
// - load_acc copies memory to accumulator, N Z; A6..F6, 2 3 4 5 4 3
// - load_index copies memory to index, N Z; AE..FE, same timing
// - left shift: bit7 to carry, zero in; 38..78, 5 3 3 6 5 cycles
// - negate: operand becomes 00 minus operand; 30..70, N Z C
// - subtract with borrow, page-zero B2, 3 cycles, N Z C
// - subtract memory from accumulator; A0..F0, 2 3 4 5 4 3, N Z C
// - store accumulator, N Z; B7..F7, 4 5 6 5 4 cycles
// - store index, N Z; BF..FF, 4 5 6 5 4 cycles
// - stop 8E, 2 cycles: clear mask, halt oscillator, enable pin
// - wait 8F, 2 cycles: stop CPU clock, clear mask only
// - copy accumulator to index, 97, 2 cycles, flags untouched
// - copy index to accumulator, 9F, 2 cycles, flags untouched
// - test compares operand with zero, sets N Z; 3D..7D, 4 3 3 5 4
// - trap 83, 10 cycles: push PCL PCH X A flags, set mask, vector
module cod_decoder (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Instruction request
   input  wire logic       op_valid,
   input  wire logic [7:0] opcode,
   input  wire logic [7:0] mem_data,
   input  wire logic [7:0] acc_in,
   input  wire logic [7:0] idx_in,
   input  wire logic [7:0] flags_in,
   // Decode results
   output logic            busy,
   output logic            done,
   output logic            illegal,
   output logic [3:0]      op_class,
   output logic [2:0]      addr_mode,
   output logic [3:0]      cycles,
   // Data results
   output logic [7:0]      result,
   output logic            write_acc,
   output logic            write_idx,
   output logic            write_mem,
   output logic [7:0]      flags_out,
   // Control effects
   output logic            stop_osc,
   output logic            stop_cpu_clk,
   output logic            ext_irq_en,
   output logic            trap_start
);
   typedef enum logic [1:0] {
      COD_ST_IDLE = 2'b00,
      COD_ST_RUN  = 2'b01,
      COD_ST_DONE = 2'b10
   } cod_state_t;

   cod_pkg::cod_op_t   dec_op;
   cod_pkg::cod_mode_t dec_mode;
   logic [3:0]         dec_cyc;
   logic [1:0]         dec_src;
   logic [3:0]         hi;
   logic [3:0]         lo;

   cod_state_t         state;
   cod_state_t         next_state;
   cod_pkg::cod_op_t   cur_op;
   cod_pkg::cod_op_t   next_cur_op;
   logic [1:0]         cur_src;
   logic [1:0]         next_cur_src;
   logic [3:0]         count;
   logic [3:0]         next_count;
   logic [7:0]         next_flags_out;
   logic [7:0]         next_result;
   logic               next_busy;
   logic               next_done;
   logic               next_illegal;
   logic [3:0]         next_op_class;
   logic [2:0]         next_addr_mode;
   logic [3:0]         next_cycles;
   logic               next_write_acc;
   logic               next_write_idx;
   logic               next_write_mem;
   logic               next_stop_osc;
   logic               next_stop_clk;
   logic               next_irq_en;
   logic               next_trap;
   logic               alu_go;
   logic [7:0]         alu_res;
   logic               alu_n;
   logic               alu_z;
   logic               alu_c;
   logic               take;

   assign hi   = opcode[7:4];
   assign lo   = opcode[3:0];
   assign take = op_valid && (state == COD_ST_IDLE);

   // Column lookup for the memory modes; timing per column
   function automatic logic [3:0] mem_cyc(input logic [3:0] col,
                                          input logic       store);
      logic [3:0] c;
      c = cod_pkg::COD_CYC_2;
      unique case (col)
         cod_pkg::COD_COL_DIR: c = store ? cod_pkg::COD_CYC_4
                                         : cod_pkg::COD_CYC_3;
         cod_pkg::COD_COL_EXT: c = store ? cod_pkg::COD_CYC_5
                                         : cod_pkg::COD_CYC_4;
         cod_pkg::COD_COL_IX2: c = store ? cod_pkg::COD_CYC_6
                                         : cod_pkg::COD_CYC_5;
         cod_pkg::COD_COL_IX1: c = store ? cod_pkg::COD_CYC_5
                                         : cod_pkg::COD_CYC_4;
         cod_pkg::COD_COL_IX:  c = store ? cod_pkg::COD_CYC_4
                                         : cod_pkg::COD_CYC_3;
         default:              c = cod_pkg::COD_CYC_2;
      endcase
      return c;
   endfunction : mem_cyc

   always_comb begin
      dec_op   = cod_pkg::COD_OP_ILLEGAL;
      dec_mode = cod_pkg::COD_MODE_NONE;
      dec_cyc  = cod_pkg::COD_CYC_2;
      dec_src  = cod_pkg::COD_SRC_MEM;
      // Upper digit first picks the column and mode
      unique case (hi)
         cod_pkg::COD_COL_RMW_DIR: dec_mode = cod_pkg::COD_MODE_PAGEZERO;
         cod_pkg::COD_COL_RMW_ACC,
         cod_pkg::COD_COL_RMW_IDX,
         cod_pkg::COD_COL_CTL_A,
         cod_pkg::COD_COL_CTL_B:   dec_mode = cod_pkg::COD_MODE_IMPLIED;
         cod_pkg::COD_COL_RMW_IX1,
         cod_pkg::COD_COL_IX1:     dec_mode = cod_pkg::COD_MODE_BYTEOFS;
         cod_pkg::COD_COL_RMW_IX,
         cod_pkg::COD_COL_IX:      dec_mode = cod_pkg::COD_MODE_NOOFS;
         cod_pkg::COD_COL_IMM:     dec_mode = cod_pkg::COD_MODE_LITERAL;
         cod_pkg::COD_COL_DIR:     dec_mode = cod_pkg::COD_MODE_PAGEZERO;
         cod_pkg::COD_COL_EXT:     dec_mode = cod_pkg::COD_MODE_FULL;
         cod_pkg::COD_COL_IX2:     dec_mode = cod_pkg::COD_MODE_WORDOFS;
         default:                  dec_mode = cod_pkg::COD_MODE_NONE;
      endcase
      if (hi == cod_pkg::COD_COL_RMW_ACC)
         dec_src = cod_pkg::COD_SRC_ACC;
      if (hi == cod_pkg::COD_COL_RMW_IDX)
         dec_src = cod_pkg::COD_SRC_IDX;
      // Lower digit picks the operation inside the column
      if (hi >= cod_pkg::COD_COL_RMW_DIR && hi <= cod_pkg::COD_COL_RMW_IX) begin
         unique case (hi)
            cod_pkg::COD_COL_RMW_DIR,
            cod_pkg::COD_COL_RMW_IX:  dec_cyc = cod_pkg::COD_CYC_5;
            cod_pkg::COD_COL_RMW_IX1: dec_cyc = cod_pkg::COD_CYC_6;
            default:                  dec_cyc = cod_pkg::COD_CYC_3;
         endcase
         if (lo == cod_pkg::COD_LO_NEGATE)
            dec_op = cod_pkg::COD_OP_NEGATE;
         else if (lo == cod_pkg::COD_LO_SHL)
            dec_op = cod_pkg::COD_OP_SHL;
         else if (lo == cod_pkg::COD_LO_TEST) begin
            dec_op  = cod_pkg::COD_OP_TEST;
            dec_cyc = dec_cyc - 4'h1;
            if (dec_mode != cod_pkg::COD_MODE_IMPLIED)
               dec_cyc = dec_cyc - 4'h0;
            if (dec_mode == cod_pkg::COD_MODE_PAGEZERO ||
                dec_mode == cod_pkg::COD_MODE_NOOFS)
               dec_cyc = cod_pkg::COD_CYC_4;
            else if (dec_mode == cod_pkg::COD_MODE_BYTEOFS)
               dec_cyc = cod_pkg::COD_CYC_5;
            else
               dec_cyc = cod_pkg::COD_CYC_3;
         end
      end else if (hi == cod_pkg::COD_COL_CTL_A) begin
         dec_cyc = cod_pkg::COD_CYC_2;
         if (lo == cod_pkg::COD_LO_TRAP) begin
            dec_op  = cod_pkg::COD_OP_TRAP;
            dec_cyc = cod_pkg::COD_CYC_10;
         end else if (lo == cod_pkg::COD_LO_STOP)
            dec_op = cod_pkg::COD_OP_STOP;
         else if (lo == cod_pkg::COD_LO_WAIT)
            dec_op = cod_pkg::COD_OP_WAIT;
      end else if (hi == cod_pkg::COD_COL_CTL_B) begin
         dec_cyc = cod_pkg::COD_CYC_2;
         if (lo == cod_pkg::COD_LO_ACC2IDX)
            dec_op = cod_pkg::COD_OP_ACC2IDX;
         else if (lo == cod_pkg::COD_LO_IDX2ACC)
            dec_op = cod_pkg::COD_OP_IDX2ACC;
      end else if (hi >= cod_pkg::COD_COL_IMM) begin
         if (lo == cod_pkg::COD_LO_SUB)
            dec_op = cod_pkg::COD_OP_SUB;
         else if (lo == cod_pkg::COD_LO_LOAD_ACC)
            dec_op = cod_pkg::COD_OP_LOAD_ACC;
         else if (lo == cod_pkg::COD_LO_LOAD_IDX)
            dec_op = cod_pkg::COD_OP_LOAD_IDX;
         else if (lo == cod_pkg::COD_LO_SUB_BRW &&
                  hi == cod_pkg::COD_COL_DIR)
            dec_op = cod_pkg::COD_OP_SUB_BRW;
         // Stores have no literal form
         else if (lo == cod_pkg::COD_LO_STR_ACC && hi != cod_pkg::COD_COL_IMM)
            dec_op = cod_pkg::COD_OP_STORE_ACC;
         else if (lo == cod_pkg::COD_LO_STR_IDX && hi != cod_pkg::COD_COL_IMM)
            dec_op = cod_pkg::COD_OP_STORE_IDX;
         dec_cyc = mem_cyc(hi, dec_op == cod_pkg::COD_OP_STORE_ACC ||
                               dec_op == cod_pkg::COD_OP_STORE_IDX);
      end
      if (dec_op == cod_pkg::COD_OP_ILLEGAL)
         dec_mode = cod_pkg::COD_MODE_NONE;
   end

   // The ALU evaluates on the acceptance cycle; results land at done
   assign alu_go = take && dec_op != cod_pkg::COD_OP_ILLEGAL;

   cod_alu u_alu (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .go       (alu_go),
      .op       (dec_op),
      .acc      (acc_in),
      .idx      (idx_in),
      .mem      (mem_data),
      .src      (dec_src),
      .carry_in (flags_in[cod_pkg::COD_FLAG_C]),
      .result   (alu_res),
      .flag_n   (alu_n),
      .flag_z   (alu_z),
      .flag_c   (alu_c)
   );

   always_comb begin
      next_state     = state;
      next_cur_op    = cur_op;
      next_cur_src   = cur_src;
      next_count     = count;
      next_busy      = busy;
      next_done      = 1'b0;
      next_illegal   = illegal;
      next_op_class  = op_class;
      next_addr_mode = addr_mode;
      next_cycles    = cycles;
      next_result    = result;
      next_flags_out = flags_out;
      next_write_acc = 1'b0;
      next_write_idx = 1'b0;
      next_write_mem = 1'b0;
      next_stop_osc  = 1'b0;
      next_stop_clk  = 1'b0;
      next_irq_en    = 1'b0;
      next_trap      = 1'b0;
      unique case (state)
         COD_ST_IDLE: begin
            if (op_valid) begin
               next_cur_op    = dec_op;
               next_cur_src   = dec_src;
               next_op_class  = dec_op;
               next_addr_mode = dec_mode;
               next_cycles    = dec_cyc;
               next_illegal   = (dec_op == cod_pkg::COD_OP_ILLEGAL);
               next_flags_out = flags_in;
               if (dec_op == cod_pkg::COD_OP_ILLEGAL) begin
                  // Illegal opcode: no state change, one-cycle done
                  next_done = 1'b1;
               end else begin
                  next_busy  = 1'b1;
                  next_count = dec_cyc - 4'h1;
                  next_state = COD_ST_RUN;
               end
            end
         end
         COD_ST_RUN: begin
            next_count = count - 4'h1;
            if (count == 4'h1) begin
               next_state = COD_ST_DONE;
            end
         end
         COD_ST_DONE: begin
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_state = COD_ST_IDLE;
            next_result = alu_res;
            unique case (cur_op)
               cod_pkg::COD_OP_ACC2IDX: begin
                  next_result    = acc_in;
                  next_write_idx = 1'b1;
               end
               cod_pkg::COD_OP_IDX2ACC: begin
                  next_result    = idx_in;
                  next_write_acc = 1'b1;
               end
               cod_pkg::COD_OP_STOP: begin
                  next_flags_out[cod_pkg::COD_FLAG_I] = 1'b0;
                  next_stop_osc = 1'b1;
                  next_irq_en   = 1'b1;
               end
               cod_pkg::COD_OP_WAIT: begin
                  next_flags_out[cod_pkg::COD_FLAG_I] = 1'b0;
                  next_stop_clk = 1'b1;
               end
               cod_pkg::COD_OP_TRAP: begin
                  next_flags_out[cod_pkg::COD_FLAG_I] = 1'b1;
                  next_trap = 1'b1;
               end
               default: begin
                  next_flags_out[cod_pkg::COD_FLAG_N] = alu_n;
                  next_flags_out[cod_pkg::COD_FLAG_Z] = alu_z;
                  if (cur_op == cod_pkg::COD_OP_SHL ||
                      cur_op == cod_pkg::COD_OP_NEGATE ||
                      cur_op == cod_pkg::COD_OP_SUB ||
                      cur_op == cod_pkg::COD_OP_SUB_BRW)
                     next_flags_out[cod_pkg::COD_FLAG_C] = alu_c;
                  next_write_acc = (cur_op == cod_pkg::COD_OP_LOAD_ACC) ||
                     (cur_op == cod_pkg::COD_OP_SUB) ||
                     (cur_op == cod_pkg::COD_OP_SUB_BRW) ||
                     ((cur_op == cod_pkg::COD_OP_SHL ||
                       cur_op == cod_pkg::COD_OP_NEGATE) &&
                      cur_src == cod_pkg::COD_SRC_ACC);
                  next_write_idx = (cur_op == cod_pkg::COD_OP_LOAD_IDX) ||
                     ((cur_op == cod_pkg::COD_OP_SHL ||
                       cur_op == cod_pkg::COD_OP_NEGATE) &&
                      cur_src == cod_pkg::COD_SRC_IDX);
                  next_write_mem = (cur_op == cod_pkg::COD_OP_STORE_ACC) ||
                     (cur_op == cod_pkg::COD_OP_STORE_IDX) ||
                     ((cur_op == cod_pkg::COD_OP_SHL ||
                       cur_op == cod_pkg::COD_OP_NEGATE) &&
                      cur_src == cod_pkg::COD_SRC_MEM);
               end
            endcase
         end
         default: next_state = COD_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state        <= COD_ST_IDLE;
         cur_op       <= cod_pkg::COD_OP_NONE;
         cur_src      <= cod_pkg::COD_SRC_MEM;
         count        <= 4'h0;
         busy         <= 1'b0;
         done         <= 1'b0;
         illegal      <= 1'b0;
         op_class     <= cod_pkg::COD_OP_NONE;
         addr_mode    <= cod_pkg::COD_MODE_NONE;
         cycles       <= 4'h0;
         result       <= 8'h00;
         flags_out    <= cod_pkg::COD_FLAGS_RST;
         write_acc    <= 1'b0;
         write_idx    <= 1'b0;
         write_mem    <= 1'b0;
         stop_osc     <= 1'b0;
         stop_cpu_clk <= 1'b0;
         ext_irq_en   <= 1'b0;
         trap_start   <= 1'b0;
      end else if (ce) begin
         state        <= next_state;
         cur_op       <= next_cur_op;
         cur_src      <= next_cur_src;
         count        <= next_count;
         busy         <= next_busy;
         done         <= next_done;
         illegal      <= next_illegal;
         op_class     <= next_op_class;
         addr_mode    <= next_addr_mode;
         cycles       <= next_cycles;
         result       <= next_result;
         flags_out    <= next_flags_out;
         write_acc    <= next_write_acc;
         write_idx    <= next_write_idx;
         write_mem    <= next_write_mem;
         stop_osc     <= next_stop_osc;
         stop_cpu_clk <= next_stop_clk;
         ext_irq_en   <= next_irq_en;
         trap_start   <= next_trap;
      end
   end
endmodule : cod_decoder

// File: design/cod_pkg.sv
package cod_pkg;

   // Operations carried out by this decoder
   typedef enum logic [3:0] {
      COD_OP_NONE      = 4'h0,
      COD_OP_LOAD_ACC  = 4'h1,
      COD_OP_LOAD_IDX  = 4'h2,
      COD_OP_SHL       = 4'h3,
      COD_OP_NEGATE    = 4'h4,
      COD_OP_SUB_BRW   = 4'h5,
      COD_OP_SUB       = 4'h6,
      COD_OP_STORE_ACC = 4'h7,
      COD_OP_STORE_IDX = 4'h8,
      COD_OP_STOP      = 4'h9,
      COD_OP_WAIT      = 4'hA,
      COD_OP_ACC2IDX   = 4'hB,
      COD_OP_IDX2ACC   = 4'hC,
      COD_OP_TEST      = 4'hD,
      COD_OP_TRAP      = 4'hE,
      COD_OP_ILLEGAL   = 4'hF
   } cod_op_t;

   // Addressing modes
   typedef enum logic [2:0] {
      COD_MODE_IMPLIED  = 3'h0,
      COD_MODE_LITERAL  = 3'h1,
      COD_MODE_PAGEZERO = 3'h2,
      COD_MODE_FULL     = 3'h3,
      COD_MODE_WORDOFS  = 3'h4,
      COD_MODE_BYTEOFS  = 3'h5,
      COD_MODE_NOOFS    = 3'h6,
      COD_MODE_NONE     = 3'h7
   } cod_mode_t;

   // Operand selector for read-modify-write columns 3..7
   localparam logic [1:0] COD_SRC_MEM = 2'h0;
   localparam logic [1:0] COD_SRC_ACC = 2'h1;
   localparam logic [1:0] COD_SRC_IDX = 2'h2;

   // Upper opcode digit of each column
   localparam logic [3:0] COD_COL_RMW_DIR = 4'h3;
   localparam logic [3:0] COD_COL_RMW_ACC = 4'h4;
   localparam logic [3:0] COD_COL_RMW_IDX = 4'h5;
   localparam logic [3:0] COD_COL_RMW_IX1 = 4'h6;
   localparam logic [3:0] COD_COL_RMW_IX  = 4'h7;
   localparam logic [3:0] COD_COL_CTL_A   = 4'h8;
   localparam logic [3:0] COD_COL_CTL_B   = 4'h9;
   localparam logic [3:0] COD_COL_IMM     = 4'hA;
   localparam logic [3:0] COD_COL_DIR     = 4'hB;
   localparam logic [3:0] COD_COL_EXT     = 4'hC;
   localparam logic [3:0] COD_COL_IX2     = 4'hD;
   localparam logic [3:0] COD_COL_IX1     = 4'hE;
   localparam logic [3:0] COD_COL_IX      = 4'hF;

   // Lower opcode digit of each operation
   localparam logic [3:0] COD_LO_SUB      = 4'h0;
   localparam logic [3:0] COD_LO_SUB_BRW  = 4'h2;
   localparam logic [3:0] COD_LO_LOAD_ACC = 4'h6;
   localparam logic [3:0] COD_LO_STR_ACC  = 4'h7;
   localparam logic [3:0] COD_LO_LOAD_IDX = 4'hE;
   localparam logic [3:0] COD_LO_STR_IDX  = 4'hF;
   localparam logic [3:0] COD_LO_NEGATE   = 4'h0;
   localparam logic [3:0] COD_LO_SHL      = 4'h8;
   localparam logic [3:0] COD_LO_TEST     = 4'hD;
   localparam logic [3:0] COD_LO_TRAP     = 4'h3;
   localparam logic [3:0] COD_LO_STOP     = 4'hE;
   localparam logic [3:0] COD_LO_WAIT     = 4'hF;
   localparam logic [3:0] COD_LO_ACC2IDX  = 4'h7;
   localparam logic [3:0] COD_LO_IDX2ACC  = 4'hF;

   // Cycle counts
   localparam logic [3:0] COD_CYC_2  = 4'h2;
   localparam logic [3:0] COD_CYC_3  = 4'h3;
   localparam logic [3:0] COD_CYC_4  = 4'h4;
   localparam logic [3:0] COD_CYC_5  = 4'h5;
   localparam logic [3:0] COD_CYC_6  = 4'h6;
   localparam logic [3:0] COD_CYC_10 = 4'hA;

   // Flag register bit positions and reset value
   localparam int         COD_FLAG_C = 0;
   localparam int         COD_FLAG_Z = 1;
   localparam int         COD_FLAG_N = 2;
   localparam int         COD_FLAG_I = 3;
   localparam logic [7:0] COD_FLAGS_RST = 8'hE8;
   localparam logic [7:0] COD_ZERO_BYTE = 8'h00;

endpackage : cod_pkg

// File: test/cod_decoder_asserts.sv
`timescale 1ns/10ps
module cod_decoder_asserts (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Request
   input wire logic       ce,
   input wire logic       op_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] flags_in,
   // Results
   input wire logic       busy,
   input wire logic       done,
   input wire logic       illegal,
   input wire logic [3:0] cycles,
   input wire logic [7:0] result,
   input wire logic [7:0] flags_out,
   input wire logic       write_mem,
   input wire logic       stop_osc,
   input wire logic       stop_cpu_clk,
   input wire logic       ext_irq_en,
   input wire logic       trap_start
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic       take;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   assign take = ce && op_valid && !busy;
   // Saturates so a hung decoder cannot wrap into a false match
   always_comb begin
      next_cnt = take ? 5'h01 : (cnt == 5'h1F ? cnt : cnt + 5'h01);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cnt <= 5'h1F;
      // Frozen with the design while ce is low
      else if (ce) cnt <= next_cnt;
   end
   AST_DONE_TIME: assert property (
      done && !illegal |-> cnt == cycles + 5'h01)
      else $error("done latency off");
   AST_LOAD_TIME: assert property (
      take && opcode == 8'hA6 |=> cycles == 4'h2 && busy ##2 done && !busy)
      else $error("load timing off");
   AST_TRAP_TIME: assert property (
      take && opcode == 8'h83 |=> !done [*8] ##3 done && trap_start)
      else $error("trap timing off");
   AST_ILLEGAL: assert property (
      take && opcode == 8'h01 |=> done && illegal)
      else $error("unmapped opcode not flagged");
   AST_STOP_FX: assert property (
      stop_osc |-> ext_irq_en && done && !flags_out[3])
      else $error("stop effects wrong");
   AST_WAIT_FX: assert property (
      stop_cpu_clk |-> done && !stop_osc && !flags_out[3])
      else $error("wait effects wrong");
   AST_COPY_FLAGS: assert property (
      take && opcode == 8'h97 |=> ##2 flags_out == $past(flags_in, 3))
      else $error("copy altered flags");
   AST_STORE_Z: assert property (
      write_mem |-> flags_out[1] == (result == 8'h00))
      else $error("store zero flag wrong");
   cover property (trap_start);
   cover property (stop_cpu_clk);
   cover property (done && illegal);
endmodule : cod_decoder_asserts

bind cod_decoder cod_decoder_asserts u_cod_decoder_asserts (.clk, .rst, .ce,
   .op_valid, .opcode, .flags_in, .busy, .done, .illegal, .cycles, .result,
   .flags_out, .write_mem, .stop_osc, .stop_cpu_clk, .ext_irq_en, .trap_start);

// File: test/cod_decoder_bench.sv
`timescale 1ns/10ps
module cod_decoder_bench;
   logic       clk, rst, ce, op_valid, busy, done, illegal;
   logic       write_acc, write_idx, write_mem, stop_osc, stop_cpu_clk;
   logic       ext_irq_en, trap_start;
   logic [7:0] opcode, mem_data, acc_in, idx_in, flags_in, result, flags_out;
   logic [3:0] op_class, cycles;
   logic [2:0] addr_mode;
   int         err_count = 0, num_checks = 0, i;
   int         mc[6] = '{2, 3, 4, 5, 4, 3};
   int         sc[5] = '{4, 5, 6, 5, 4};
   int         rc[5] = '{5, 3, 3, 6, 5};
   int         tc[5] = '{4, 3, 3, 5, 4};
   cod_decoder u_cod_decoder (.clk, .rst, .ce, .op_valid, .opcode,
      .mem_data, .acc_in, .idx_in, .flags_in, .busy, .done, .illegal,
      .op_class, .addr_mode, .cycles, .result, .write_acc, .write_idx,
      .write_mem, .flags_out, .stop_osc, .stop_cpu_clk, .ext_irq_en,
      .trap_start);
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Leaves the bench at the falling edge where done is seen
   task go(input logic [39:0] req, output int n);
      @(negedge clk);
      {opcode, mem_data, acc_in, idx_in, flags_in} = req;
      op_valid = 1'b1;
      @(negedge clk);
      op_valid = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
   endtask : go
   task lat(input logic [7:0] op, input int c);
      int n;
      go({op, 32'h0000_0000}, n);
      chk(8'(n), 8'(c + 1));
      chk({7'h00, illegal}, {7'h00, c == 0});
      if (c > 1) chk({4'h0, cycles}, 8'(c));
   endtask : lat
   // ce low must freeze the count; done comes as many cycles later
   task t_freeze;
      @(negedge clk);
      {opcode, mem_data, acc_in, idx_in, flags_in} = 40'hB6_5500_0000;
      op_valid = 1'b1;
      @(negedge clk);
      op_valid = 1'b0;
      ce = 1'b0;
      repeat (5) @(negedge clk);
      chk({6'h00, busy, done}, 8'h02);
      ce = 1'b1;
      repeat (3) @(negedge clk);
      chk({7'h00, done}, 8'h01);
      chk(result, 8'h55);
   endtask : t_freeze
   // Fields: opcode, mem, acc, idx, flags, result, flags out, strobes
   task dat(input logic [63:0] v);
      int n;
      go(v[63:24], n);
      if (v[7:5] != 3'b000) chk(result, v[23:16]);
      chk(flags_out, v[15:8]);
      chk({write_acc, write_idx, write_mem, stop_osc, stop_cpu_clk,
           ext_irq_en, trap_start, illegal}, v[7:0]);
   endtask : dat
   task t_timing;
      for (i = 0; i < 6; i++) begin
         lat({4'hA + 4'(i), 4'h6}, mc[i]);
         lat({4'hA + 4'(i), 4'hE}, mc[i]);
         lat({4'hA + 4'(i), 4'h0}, mc[i]);
         chk(8'(addr_mode), 8'(cod_pkg::COD_MODE_LITERAL + i));
         chk(8'(op_class), 8'(cod_pkg::COD_OP_SUB));
      end
      for (i = 0; i < 5; i++) begin
         lat({4'hB + 4'(i), 4'h7}, sc[i]);
         lat({4'hB + 4'(i), 4'hF}, sc[i]);
         lat({4'h3 + 4'(i), 4'h8}, rc[i]);
         lat({4'h3 + 4'(i), 4'h0}, rc[i]);
         lat({4'h3 + 4'(i), 4'hD}, tc[i]);
      end
      lat(8'hB2, 3);
      lat(8'h8E, 2);
      lat(8'h8F, 2);
      lat(8'h97, 2);
      lat(8'h9F, 2);
      lat(8'h83, 10);
      lat(8'h01, 0);
      lat(8'hA9, 0);
      lat(8'hA2, 0);
   endtask : t_timing
   task t_data;
      dat(64'hA680_0000_0080_0480);
      dat(64'hAE00_1122_0000_0240);
      dat(64'h4800_8100_0002_0180);
      dat(64'h4000_0100_00FF_0580);
      dat(64'hB203_0500_0101_0080);
      dat(64'hA005_0300_00FE_0580);
      dat(64'hB700_0000_0400_0220);
      dat(64'hBF00_007F_027F_0020);
      dat(64'h8E00_0000_0800_0014);
      dat(64'h8F00_0000_0F00_0708);
      dat(64'h9700_5500_0755_0740);
      dat(64'h9F00_0080_0080_0080);
      dat(64'h4D00_0000_0500_0300);
      dat(64'h8300_0000_0000_0802);
   endtask : t_data
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      err_count++;
      report_and_stop;
   end
   initial begin
      rst = 1'b1;
      op_valid = 1'b0;
      ce = 1'b1;
      {opcode, mem_data, acc_in, idx_in, flags_in} = 40'h00_0000_0000;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      chk(flags_out, 8'hE8);
      t_timing;
      t_data;
      t_freeze;
      report_and_stop;
   end
endmodule : cod_decoder_bench
